// file: testbench/sqi_seq_model.sv
/* Sequencer side model: drives line completions and single conversions,
   and counts the host's view of the interrupt pin.
   Assumes its task is started just after a rising edge. */
`timescale 1ns/100ps
module sqi_seq_model (
  // clock and pin
  input wire logic core_clk_i,
  input wire logic irq_pin_i,
  // unit progress
  output logic [1:0] line_done_o,
  output logic [3:0] ptr1_o,
  output logic [3:0] ptr2_o,
  output logic single_done_o
);
  int pin_count = 0;
  initial begin
    line_done_o = 2'h0;
    ptr1_o = 4'h0;
    ptr2_o = 4'h0;
    single_done_o = 1'b0;
  end
  // one count per high cycle, so a stretched pulse is seen as two
  always @(posedge core_clk_i) begin
    if (irq_pin_i === 1'b1) pin_count++;
  end
  // one progress cycle; pointers scrambled once no longer qualified
  task automatic step(input logic [1:0] ld, input logic [3:0] p1, input logic [3:0] p2,
      input logic sd);
    line_done_o <= ld;
    ptr1_o <= p1;
    ptr2_o <= p2;
    single_done_o <= sd;
    @(posedge core_clk_i);
    line_done_o <= 2'h0;
    ptr1_o <= ~p1;
    ptr2_o <= ~p2;
    single_done_o <= 1'b0;
    @(posedge core_clk_i);
  endtask
endmodule

// file: testbench/tb_sequencer_interrupt_logic.sv
/* Bench for the sequencer interrupt logic: APB master, one task per
   scenario, sequencer model on the unit side.
   Assumes a one-cycle APB answer and a two-cycle event latency. */
`timescale 1ns/100ps
module tb_sequencer_interrupt_logic;
  import sqi_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq_pin, irq, err, single_done;
  logic [1:0] run_en, line_done;
  logic [3:0] ptr1, ptr2;
  int bad_count = 0;
  int checks_done = 0;
  int base = 0;

  sqi_irq_logic dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_done_i(line_done),
    .next_line_pointer1_i(ptr1), .next_line_pointer2_i(ptr2), .single_done_i(single_done),
    .unit_run_enable_o(run_en), .irq_pin_o(irq_pin), .irq_o(irq));
  sqi_seq_model seq (.core_clk_i(core_clk_i), .irq_pin_i(irq_pin), .line_done_o(line_done),
    .ptr1_o(ptr1), .ptr2_o(ptr2), .single_done_o(single_done));

  // 50 ns clock
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; trailing edge keeps back-to-back calls from colliding
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // pin pulses since last call; the pin answers two cycles after the event
  task automatic pins(input int exp);
    repeat (4) @(posedge core_clk_i);
    chk(seq.pin_count - base, exp);
    base = seq.pin_count;
  endtask

  task automatic t_reset;
    rdchk(OFS_MASK_FLAGS, 32'h0);
    rdchk(OFS_UNIT_CTRL, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h0);
    rdchk(OFS_IRQ_ENABLE, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_open;
    apb(1'b1, OFS_UNIT_CTRL, 32'h3);
    chk({30'h0, run_en}, 32'h3);
    seq.step(2'h1, 4'h3, 4'h0, 1'b0);
    pins(0);
    seq.step(2'h1, 4'hF, 4'h0, 1'b0);
    pins(1);
    rdchk(OFS_MASK_FLAGS, 32'h10);
    rdchk(OFS_MASK_FLAGS, 32'h0);
    seq.step(2'h2, 4'h0, 4'hF, 1'b0);
    pins(1);
    rdchk(OFS_MASK_FLAGS, 32'h20);
    $display("test open loop done");
  endtask

  task automatic t_closed;
    apb(1'b1, OFS_UNIT_CTRL, 32'hF);
    apb(1'b1, OFS_MASK_FLAGS, 32'h9500);
    rdchk(OFS_MASK_FLAGS, 32'h0);
    seq.step(2'h1, 4'h5, 4'h0, 1'b0);
    pins(1);
    seq.step(2'h1, 4'hF, 4'h0, 1'b0);
    pins(0);
    seq.step(2'h2, 4'h0, 4'h9, 1'b0);
    pins(1);
    rdchk(OFS_MASK_FLAGS, 32'h30);
    $display("test closed loop done");
  endtask

  // masks stop the pin only; select fields now zero
  task automatic t_mask;
    apb(1'b1, OFS_MASK_FLAGS, 32'h7);
    seq.step(2'h0, 4'h0, 4'h0, 1'b1);
    pins(0);
    rdchk(OFS_MASK_FLAGS, 32'hF);
    seq.step(2'h3, 4'h0, 4'h0, 1'b0);
    pins(0);
    rdchk(OFS_MASK_FLAGS, 32'h37);
    apb(1'b1, OFS_MASK_FLAGS, 32'h0);
    seq.step(2'h0, 4'h0, 4'h0, 1'b1);
    pins(1);
    seq.step(2'h3, 4'h0, 4'h0, 1'b1);
    pins(1);
    rdchk(OFS_MASK_FLAGS, 32'h38);
    $display("test mask done");
  endtask

  task automatic t_stop;
    apb(1'b1, OFS_UNIT_CTRL, 32'hC);
    chk({30'h0, run_en}, 32'h0);
    seq.step(2'h3, 4'h0, 4'h0, 1'b0);
    pins(0);
    rdchk(OFS_MASK_FLAGS, 32'h0);
    $display("test stop done");
  endtask

  // sticky status, enable and write-one-to-clear, unmapped address
  task automatic t_irq;
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    rdchk(OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h7);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_UNIT_CTRL, 32'h1);
    seq.step(2'h1, 4'hF, 4'h0, 1'b0);
    pins(1);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h6);
    seq.step(2'h0, 4'h0, 4'h0, 1'b1);
    pins(1);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test irq done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_open();
    t_closed();
    t_mask();
    t_stop();
    t_irq();
    test_done();
  end

  // watchdog, far beyond the roughly 170 cycles the tests need
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule

// file: verilog/sqi_irq_logic.sv
/*
 * Sequencer interrupt logic: APB register slave, per-source flags that
 * clear on read, mask bits, pin pulse and a sticky-status interrupt.
 * Assumes the units report finished lines and single conversions as
 * one-cycle pulses synchronous to core_clk_i.
 */
// Our own choices: the APB register port and the address map.
// Summary of operation
// - any unit meeting its interrupt condition can pulse the interrupt pin.
// - each of the three sources has a mask bit and a one suppresses its pin pulse.
// - a raised source sets its own flag in the mask-and-flag register.
// - flags are set even while the source is masked; masks gate only the pin.
// - reading the mask-and-flag register clears the flags that were set at the read.
// - in open loop a unit interrupts when its next line pointer selects the loop end.
// - in closed loop a unit interrupts when the next line pointer equals its select field.
// - the line select fields are write only and read back as zero.
// - the single conversion unit interrupts when its conversion completes.
// - a unit whose run enable is cleared finishes and stops without interrupting.
`timescale 1ns/100ps
module sqi_irq_logic (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [sqi_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // execution unit progress
  input wire logic [1:0] line_done_i,
  input wire logic [sqi_pkg::LINE_W-1:0] next_line_pointer1_i,
  input wire logic [sqi_pkg::LINE_W-1:0] next_line_pointer2_i,
  input wire logic single_done_i,
  // unit run enables toward the sequencer
  output logic [1:0] unit_run_enable_o,
  // interrupt pin and system interrupt
  output logic irq_pin_o,
  output logic irq_o
);
  import sqi_pkg::*;

  logic [1:0] unit_irq_mask_q, unit_irq_mask_d;
  logic single_irq_mask_q, single_irq_mask_d;
  logic [1:0] unit_irq_flag_q, unit_irq_flag_d;
  logic single_irq_flag_q, single_irq_flag_d;
  logic [LINE_W-1:0] sel1_q, sel1_d, sel2_q, sel2_d;
  logic [1:0] run_en_q, run_en_d;
  logic [1:0] closed_q, closed_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] ien_q, ien_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  logic [2:0] cond;
  logic [1:0] unit_cond;
  logic single_cond_q, single_cond_d;
  logic pin_pulse;
  logic setup, access, wr, rd, rd_done, hit;
  // packed views used by the pulse folder and the checks below
  logic [2:0] all_flags, all_masks, live_cond, read_flags, wd_masks;

  // per-unit views so one watcher loop can index them
  logic [LINE_W-1:0] unit_ptr [2];
  logic [LINE_W-1:0] unit_sel [2];
  assign unit_ptr[0] = next_line_pointer1_i;
  assign unit_ptr[1] = next_line_pointer2_i;
  assign unit_sel[0] = sel1_q;
  assign unit_sel[1] = sel2_q;

  // execution unit watchers, one per unit
  for (genvar u = 0; u < 2; u++) begin : g_watch
    sqi_unit_watch u_watch (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .run_enable_i(run_en_q[u]),
      .closed_loop_i(closed_q[u]),
      .line_select_i(unit_sel[u]),
      .line_done_i(line_done_i[u]),
      .next_line_pointer_i(unit_ptr[u]),
      .irq_cond_o(unit_cond[u])
    );
  end

  // single conversion completion, delayed one cycle so it lines up
  // with the registered unit conditions
  always_comb begin
    single_cond_d = single_done_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      single_cond_q <= 1'b0;
    end else begin
      single_cond_q <= single_cond_d;
    end
  end

  assign cond = {unit_cond, single_cond_q};

  sqi_pulse_gen u_pulse (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .cond_i(cond),
    .mask_i(all_masks),
    .pulse_o(pin_pulse)
  );

  // apb decode; access phase answers in its first cycle
  // writes and the read clear wait for the completing edge, so a
  // transfer the master abandons in setup leaves no trace
  always_comb begin
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && pready_q;
    wr = access && pwrite_i;
    rd = setup && !pwrite_i;
    rd_done = access && !pwrite_i;
    hit = (paddr_i == OFS_MASK_FLAGS) || (paddr_i == OFS_UNIT_CTRL) ||
          (paddr_i == OFS_IRQ_STATUS) || (paddr_i == OFS_IRQ_ENABLE);
  end

  // register file next state; read word captured at setup, writes land
  // at the access edge together with pready
  always_comb begin
    unit_irq_mask_d = unit_irq_mask_q;
    single_irq_mask_d = single_irq_mask_q;
    sel1_d = sel1_q;
    sel2_d = sel2_q;
    run_en_d = run_en_q;
    closed_d = closed_q;
    ien_d = ien_q;
    unit_irq_flag_d = unit_irq_flag_q;
    single_irq_flag_d = single_irq_flag_q;
    stat_d = stat_q;
    prdata_d = RD_ZERO;
    pready_d = setup;
    pslverr_d = setup && !hit;
    // read clears only what was visible; a new event still sets
    if (rd && paddr_i == OFS_MASK_FLAGS) begin
      prdata_d[FLD_SINGLE_MASK] = single_irq_mask_q;
      prdata_d[FLD_UNIT_MASK +: 2] = unit_irq_mask_q;
      prdata_d[FLD_SINGLE_FLAG] = single_irq_flag_q;
      prdata_d[FLD_UNIT_FLAG +: 2] = unit_irq_flag_q; // select fields stay zero
    end
    // clear only the flags the captured word showed, so a later set survives
    if (rd_done && paddr_i == OFS_MASK_FLAGS) begin
      unit_irq_flag_d = unit_irq_flag_q & ~prdata_q[FLD_UNIT_FLAG +: 2];
      single_irq_flag_d = single_irq_flag_q & ~prdata_q[FLD_SINGLE_FLAG];
    end
    if (rd && paddr_i == OFS_UNIT_CTRL) begin
      prdata_d[FLD_RUN_EN +: 2] = run_en_q;
      prdata_d[FLD_CLOSED +: 2] = closed_q;
    end
    if (rd && paddr_i == OFS_IRQ_STATUS) begin
      prdata_d[2:0] = stat_q;
    end
    if (rd && paddr_i == OFS_IRQ_ENABLE) begin
      prdata_d[2:0] = ien_q;
    end
    if (wr && paddr_i == OFS_MASK_FLAGS) begin
      single_irq_mask_d = pwdata_i[FLD_SINGLE_MASK];
      unit_irq_mask_d = pwdata_i[FLD_UNIT_MASK +: 2];
      sel1_d = pwdata_i[FLD_SEL1 +: LINE_W];
      sel2_d = pwdata_i[FLD_SEL2 +: LINE_W];
    end
    if (wr && paddr_i == OFS_UNIT_CTRL) begin
      run_en_d = pwdata_i[FLD_RUN_EN +: 2];
      closed_d = pwdata_i[FLD_CLOSED +: 2];
    end
    if (wr && paddr_i == OFS_IRQ_STATUS) begin
      stat_d = stat_q & ~pwdata_i[2:0];
    end
    if (wr && paddr_i == OFS_IRQ_ENABLE) begin
      ien_d = pwdata_i[2:0];
    end
    // hardware set wins over clear, regardless of mask
    unit_irq_flag_d = unit_irq_flag_d | unit_cond;
    single_irq_flag_d = single_irq_flag_d | single_cond_q;
    stat_d = stat_d | cond;
    irq_d = |(stat_d & ien_d);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unit_irq_mask_q <= RST_MASK[2:1];
      single_irq_mask_q <= RST_MASK[0];
      unit_irq_flag_q <= 2'h0;
      single_irq_flag_q <= 1'b0;
      sel1_q <= RST_SEL;
      sel2_q <= RST_SEL;
      run_en_q <= 2'h0;
      closed_q <= 2'h0;
      stat_q <= 3'h0;
      ien_q <= 3'h0;
      prdata_q <= RD_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      unit_irq_mask_q <= unit_irq_mask_d;
      single_irq_mask_q <= single_irq_mask_d;
      unit_irq_flag_q <= unit_irq_flag_d;
      single_irq_flag_q <= single_irq_flag_d;
      sel1_q <= sel1_d;
      sel2_q <= sel2_d;
      run_en_q <= run_en_d;
      closed_q <= closed_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign unit_run_enable_o = run_en_q;
  assign irq_pin_o = pin_pulse;
  assign irq_o = irq_q;

  // packed views for the pulse folder and the checks
  assign all_flags = {unit_irq_flag_q, single_irq_flag_q};
  assign all_masks = {unit_irq_mask_q, single_irq_mask_q};
  assign live_cond = cond & ~all_masks;
  assign read_flags = {prdata_o[FLD_UNIT_FLAG +: 2], prdata_o[FLD_SINGLE_FLAG]};
  assign wd_masks = {pwdata_i[FLD_UNIT_MASK +: 2], pwdata_i[FLD_SINGLE_MASK]};

  // flag checks: cleared by the completing read, kept otherwise
  sequence s_flag_read;
    rd_done && (paddr_i == OFS_MASK_FLAGS) && (cond == 3'h0);
  endsequence

  property p_read_clears;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_flag_read |=> (all_flags & $past(read_flags)) == 3'h0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags survived read");

  property p_flag_holds;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !(rd_done && paddr_i == OFS_MASK_FLAGS) |=>
      (all_flags & $past(all_flags)) == $past(all_flags);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag lost without read");

  property p_flag_sets;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cond != 3'h0) |=> (all_flags & $past(cond)) == $past(cond);
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag not set");

  property p_sel_reads_zero;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (rd && paddr_i == OFS_MASK_FLAGS) |=> prdata_o[15:8] == 8'h00;
  endproperty
  a_sel_reads_zero: assert property (p_sel_reads_zero) else $error("select readable");

  // loop end of unit one leaves its flag two edges later, mask or not
  sequence s_unit1_end;
    line_done_i[0] && run_en_q[0] && !closed_q[0] && (next_line_pointer1_i == LOOP_END_CODE);
  endsequence

  property p_open_end_flag;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_unit1_end |-> ##2 unit_irq_flag_q[0];
  endproperty
  a_open_end_flag: assert property (p_open_end_flag) else $error("loop end left no flag");

  property p_single_flag;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    single_done_i |-> ##2 single_irq_flag_q;
  endproperty
  a_single_flag: assert property (p_single_flag) else $error("single done left no flag");

  // pin checks
  property p_pin_one_cycle;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (irq_pin_o && (live_cond == 3'h0)) |=> !irq_pin_o;
  endproperty
  a_pin_one_cycle: assert property (p_pin_one_cycle) else $error("pin pulse stretched");

  property p_pin_follows;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(irq_pin_o) |-> ($past(live_cond) != 3'h0);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin without cause");

  property p_single_done;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (single_done_i && !single_irq_mask_q) |-> ##2 irq_pin_o;
  endproperty
  a_single_done: assert property (p_single_done) else $error("single done lost");

  // register bus checks
  property p_wr_mask;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (wr && paddr_i == OFS_MASK_FLAGS) |=> all_masks == $past(wd_masks);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("mask write lost");

  property p_ready_pulse;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pready_o && penable_i) |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_ready;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule

// file: verilog/sqi_pkg.sv
/*
 * Package for the sequencer interrupt logic: register map, field layout,
 * reset values and unit interface encodings.
 * Assumes a 32-bit APB master and a single 20 MHz core clock.
 */
package sqi_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned LINE_W = 4;
  // register byte addresses
  localparam logic [7:0] OFS_MASK_FLAGS = 8'h00;
  localparam logic [7:0] OFS_UNIT_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
  // mask-and-flag register fields
  localparam int unsigned FLD_UNIT_MASK = 1;
  localparam int unsigned FLD_SINGLE_MASK = 0;
  localparam int unsigned FLD_UNIT_FLAG = 4;
  localparam int unsigned FLD_SINGLE_FLAG = 3;
  localparam int unsigned FLD_SEL1 = 8;
  localparam int unsigned FLD_SEL2 = 12;
  // unit control register fields
  localparam int unsigned FLD_RUN_EN = 0;
  localparam int unsigned FLD_CLOSED = 2;
  // reset values and the open loop end code
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [3:0] LOOP_END_CODE = 4'hF;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// file: verilog/sqi_pulse_gen.sv
/*
 * Folds masked interrupt conditions into a single one-cycle pin pulse.
 * Assumes condition inputs are single-cycle pulses from the core clock.
 */
`timescale 1ns/100ps
module sqi_pulse_gen (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // conditions and masks
  input wire logic [2:0] cond_i,
  input wire logic [2:0] mask_i,
  // pin
  output logic pulse_o
);
  import sqi_pkg::*;
  logic pulse_d;
  logic pulse_q;

  // one pulse however many unmasked sources fire together
  always_comb begin
    pulse_d = |(cond_i & ~mask_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign pulse_o = pulse_q;

  property p_pulse_masked;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    ((cond_i & ~mask_i) == 3'h0) |=> !pulse_o;
  endproperty
  a_pulse_masked: assert property (p_pulse_masked) else $error("masked source pulsed");

  property p_pulse_fire;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    ((cond_i & ~mask_i) != 3'h0) |=> pulse_o;
  endproperty
  a_pulse_fire: assert property (p_pulse_fire) else $error("unmasked source lost");
endmodule

// file: verilog/sqi_unit_watch.sv
/*
 * Watches one sequence execution unit's line completions and decides
 * when it meets its interrupt condition.
 * Assumes line_done_i pulses once per finished command line with the
 * next line pointer valid in the same cycle.
 */
`timescale 1ns/100ps
module sqi_unit_watch (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic run_enable_i,
  input wire logic closed_loop_i,
  input wire logic [sqi_pkg::LINE_W-1:0] line_select_i,
  // unit progress
  input wire logic line_done_i,
  input wire logic [sqi_pkg::LINE_W-1:0] next_line_pointer_i,
  // condition pulse
  output logic irq_cond_o
);
  import sqi_pkg::*;
  logic cond_d;
  logic cond_q;

  // open loop ends on the marker, closed loop on the selected line
  always_comb begin
    cond_d = 1'b0;
    if (line_done_i && run_enable_i) begin
      if (closed_loop_i) begin
        cond_d = (next_line_pointer_i == line_select_i);
      end else begin
        cond_d = (next_line_pointer_i == LOOP_END_CODE);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
    end
  end

  assign irq_cond_o = cond_q;

  property p_unit_open;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (line_done_i && run_enable_i && !closed_loop_i &&
     next_line_pointer_i == LOOP_END_CODE) |=> irq_cond_o;
  endproperty
  a_unit_open: assert property (p_unit_open) else $error("open loop end missed");

  property p_unit_closed;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (line_done_i && run_enable_i && closed_loop_i) |=>
      (irq_cond_o == ($past(next_line_pointer_i) == $past(line_select_i)));
  endproperty
  a_unit_closed: assert property (p_unit_closed) else $error("closed loop match wrong");

  property p_unit_stopped;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !run_enable_i |=> !irq_cond_o;
  endproperty
  a_unit_stopped: assert property (p_unit_stopped) else $error("stopped unit raised");
endmodule
